// File: verif/slot_map_sink.sv
// Purpose: far-side model, latches the slot map the serial host works from
// Assumes: one clock, placement ports of the bank
// Notes: one clock of capture delay, no opinion on the values
`timescale 1ns/1ns
module slot_map_sink (
    // clock
    input wire logic clk,
    // placement from the bank
    input wire logic [2:0] line_sel,
    input wire logic [2:0][5:0] slot_code,
    input wire logic [2:0] right_phase,
    input wire logic [2:0][4:0] phase_slot,
    // captured view
    output logic [2:0][12:0] seen
);
    always_ff @(posedge clk) begin
        for (int i = 0; i < 3; i++) begin
            seen[i] <= {line_sel[i], slot_code[i], right_phase[i], phase_slot[i]};
        end
    end
endmodule

// File: verif/tb_audio_slot_assign_ch3_to_ch5.sv
// Purpose: self-checking bench for the channel 3..5 slot bank
// Assumes: AXI4-Lite master driven right after rising edges
// Notes: results queued by the driver, compared by the monitor
`timescale 1ns/1ns
module tb_audio_slot_assign_ch3_to_ch5
    import slot_cfg_pkg::*;
;
    logic clk = 0, resetn = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, x = 32'd27873, d;
    logic [3:0] wstrb = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [2:0] ls, rp;
    logic [2:0][5:0] sc;
    logic [2:0][4:0] ps;
    logic [2:0][12:0] seen;
    logic [6:0] cfg [3];
    logic [5:0] bound [4] = '{6'h00, 6'h1f, 6'h20, 6'h3f};
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    int n_mismatch = 0, tests_run = 0, cyc = 0;

    slot_cfg_bank i_dut (.clk(clk), .resetn(resetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .chan_line_select(ls), .chan_slot_code(sc),
        .chan_right_phase(rp), .chan_phase_slot(ps));
    slot_map_sink i_sink (.clk(clk), .line_sel(ls), .slot_code(sc), .right_phase(rp),
        .phase_slot(ps), .seen(seen));

    always #5 clk = ~clk;

    task automatic final_report();
        if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk_resp(input logic [1:0] e, input logic [1:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR bresp expected %h seen %h", e, g);
        end
    endtask

    task automatic chk_read(input logic [33:0] e, input logic [33:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR read expected %h seen %h", e, g);
        end
    endtask

    task automatic chk_place(input logic [12:0] e, input logic [12:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR place expected %h seen %h", e, g);
        end
    endtask

    function automatic logic [31:0] xs();
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction

    function automatic logic [7:0] adr(input int i);
        return {CH3_INDEX + 6'(i), 2'h0};
    endfunction

    // left n below 32, right n-32 above
    function automatic logic [12:0] place(input logic [6:0] c);
        return {c[6], c[5:0], c[5:0] > 6'd31, c[4:0]};
    endfunction

    // awready/wready sampled at the edge, before that edge's updates land
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
            input logic [1:0] r);
        logic aw, w;
        aw = 0;
        w = 0;
        @(posedge clk);
        bq.push_back(r);
        awaddr <= a;
        wdata <= v;
        wstrb <= s;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!(aw && w)) begin
            @(posedge clk);
            if (!aw && awready) begin
                aw = 1;
                awvalid <= 0;
            end
            if (!w && wready) begin
                w = 1;
                wvalid <= 0;
            end
        end
        do @(posedge clk); while (!bvalid);
        bready <= 0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        @(posedge clk);
        rq.push_back(e);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(posedge clk); while (!arready);
        arvalid <= 0;
        do @(posedge clk); while (!rvalid);
        rready <= 0;
    endtask

    // ceiling well above the fewer than two hundred cycles the scenarios need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            final_report();
        end
    end

    always @(posedge clk) begin
        if (bvalid && bready) chk_resp(bq.pop_front(), bresp);
        if (rvalid && rready) chk_read(rq.pop_front(), {rresp, rdata});
    end

    // registers and placement back at their reset values
    task automatic check_defaults();
        for (int i = 0; i < 3; i++) begin
            cfg[i] = 7'(i + 2);
            rd(adr(i), {RESP_OKAY, 25'h0, cfg[i]});
            chk_place(place(cfg[i]), seen[i]);
        end
    endtask

    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1;
        check_defaults();
        for (int n = 0; n < 15; n++) begin
            d = xs();
            if (n < 12) d[5:0] = bound[n % 4];
            wr(adr(n % 3), d, 4'hf, RESP_OKAY);
            cfg[n % 3] = d[6:0];
            rd(adr(n % 3), {RESP_OKAY, 25'h0, cfg[n % 3]});
            repeat (2) @(posedge clk);
            chk_place(place(cfg[n % 3]), seen[n % 3]);
        end
        // strobe off keeps the stored fields
        wr(adr(1), xs(), 4'he, RESP_OKAY);
        rd(adr(1), {RESP_OKAY, 25'h0, cfg[1]});
        wr(8'h40, xs(), 4'hf, RESP_SLVERR);
        rd(8'h40, {RESP_SLVERR, 32'h0});
        // second reset, after every field has been rewritten
        resetn <= 0;
        repeat (2) @(posedge clk);
        resetn <= 1;
        check_defaults();
        repeat (4) @(posedge clk);
        final_report();
    end
endmodule

// File: verilog/slot_cfg_bank.sv
// Purpose: AXI4-Lite register bank placing recorded channels 3..5 on the serial port
// Assumes: one write and one read outstanding at most, per AXI4-Lite
// Notes: registers sit at byte address 4 * index; bit 7 reads zero
//
// Functional notes
// - bit 6 picks primary or secondary line
// - codes 0-31: frame slot n, left n
// - codes 32-63: frame slot n, right n-32
// - channel 3 resets to slot 2, primary
// - channel 4 resets to slot 3, primary
// - channel 5 resets to slot 4, primary
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ns
module slot_cfg_bank
    import slot_cfg_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // write address and data
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // placement per channel, index 0 is channel 3
    output logic [2:0] chan_line_select,
    output logic [2:0][5:0] chan_slot_code,
    output logic [2:0] chan_right_phase,
    output logic [2:0][4:0] chan_phase_slot
);
    if (ADDR_W < 6) begin : g_bad_width
        $error("ADDR_W must reach the highest register");
    end

    typedef struct packed {
        logic aw_held;
        logic [ADDR_W-1:0] aw_addr;
        logic w_held;
        logic [6:0] w_data;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [6:0] rdata;
        logic [1:0] rresp;
        logic [2:0][6:0] cfg;
    } bank_state_t;

    bank_state_t st;
    bank_state_t next_st;
    logic [1:0] wsel;
    logic [1:0] rsel;

    // shared by the write and read paths; low two address bits ignored
    function automatic logic [1:0] reg_select(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-3:0] idx;
        idx = addr[ADDR_W-1:2];
        if (idx == (ADDR_W-2)'(CH3_INDEX)) begin
            return 2'h0;
        end else if (idx == (ADDR_W-2)'(CH4_INDEX)) begin
            return 2'h1;
        end else if (idx == (ADDR_W-2)'(CH5_INDEX)) begin
            return 2'h2;
        end
        return SEL_NONE;
    endfunction

    // no new write is taken until its response has been accepted
    assign s_axi_awready = !st.aw_held && !st.bvalid;
    assign s_axi_wready = !st.w_held && !st.bvalid;
    // a read stalls one cycle behind its own answer; cheaper than a skid buffer
    assign s_axi_arready = !st.rvalid;
    assign wsel = reg_select(st.aw_addr);
    assign rsel = reg_select(s_axi_araddr);

    always_comb begin
        next_st = st;
        // address and data may come in either order, so each is held
        if (s_axi_awvalid && s_axi_awready) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_st.w_held = 1'b1;
            // bit 7 is dropped here, so it never reaches storage
            next_st.w_data = s_axi_wdata[6:0];
            next_st.w_lane0 = s_axi_wstrb[0];
        end
        if (st.aw_held && st.w_held) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            if (wsel != SEL_NONE && st.w_lane0) begin
                next_st.cfg[wsel] = st.w_data;
            end
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        // unmapped reads answer zero with an error response
        if (s_axi_arvalid && s_axi_arready) begin
            next_st.rvalid = 1'b1;
            next_st.rdata = (rsel == SEL_NONE) ? 7'h00 : st.cfg[rsel];
            next_st.rresp = (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
    end

    // decoders reset to zero, so placement shows zero until one clock after release
    always_ff @(posedge clk) begin
        if (!resetn) begin
            st <= '0;
            st.cfg <= CFG_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rresp = st.rresp;
    assign s_axi_rdata = {25'h0, st.rdata};

    // one decoder per channel, index 0 is channel 3
    for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
        slot_cfg_if sc ();
        assign sc.cfg = st.cfg[c];
        slot_decoder u_dec (
            .clk(clk),
            .resetn(resetn),
            .sc(sc)
        );
        assign chan_line_select[c] = sc.line_sel;
        assign chan_slot_code[c] = sc.frame_slot;
        assign chan_right_phase[c] = sc.right_phase;
        assign chan_phase_slot[c] = sc.phase_slot;

        // placement trails the stored fields by exactly one clock
        line_track_a: assert property (@(posedge clk) disable iff (!resetn)
            $past(resetn) |-> chan_line_select[c] == $past(st.cfg[c][LINE_SEL_BIT]))
            else $error("line select not tracked");
        slot_follow_a: assert property (@(posedge clk) disable iff (!resetn)
            $past(resetn) |-> chan_slot_code[c] == $past(st.cfg[c][SLOT_MSB:0]))
            else $error("slot code not applied");
        phase_pick_a: assert property (@(posedge clk) disable iff (!resetn)
            $past(resetn) |-> chan_right_phase[c] == $past(st.cfg[c][PHASE_BIT]))
            else $error("phase choice not applied");
        read_match_a: assert property (@(posedge clk) disable iff (!resetn)
            s_axi_arvalid && s_axi_arready && rsel == 2'(c) |=>
            s_axi_rvalid && s_axi_rdata[6:0] == $past(st.cfg[c]))
            else $error("channel read data wrong");
    end

    sequence write_done_s;
        st.aw_held && st.w_held && wsel != SEL_NONE && st.w_lane0;
    endsequence

    ch3_reset_a: assert property (@(posedge clk)
        !resetn |=> st.cfg[0] == 7'h02) else $error("channel 3 reset wrong");
    ch4_reset_a: assert property (@(posedge clk)
        !resetn |=> st.cfg[1] == 7'h03) else $error("channel 4 reset wrong");
    ch5_reset_a: assert property (@(posedge clk)
        !resetn |=> st.cfg[2] == 7'h04) else $error("channel 5 reset wrong");
    reserved_zero_a: assert property (@(posedge clk) disable iff (!resetn)
        s_axi_rvalid |-> s_axi_rdata[31:7] == 25'h0)
        else $error("reserved bits read nonzero");
    write_store_a: assert property (@(posedge clk) disable iff (!resetn)
        write_done_s |=> st.cfg[$past(wsel)] == $past(st.w_data))
        else $error("write not stored");
    line_follow_a: assert property (@(posedge clk) disable iff (!resetn)
        write_done_s ##1 1'b1 ##1 1'b1 |->
        chan_line_select[$past(wsel, 2)] == $past(st.w_data[6], 2))
        else $error("line select not applied");
    read_back_a: assert property (@(posedge clk) disable iff (!resetn)
        s_axi_arvalid && s_axi_arready && rsel == 2'h0 |=>
        s_axi_rvalid && s_axi_rdata[6:0] == $past(st.cfg[0]))
        else $error("read data wrong");

    // a write held in full this cycle
    sequence pair_held_s;
        st.aw_held && st.w_held;
    endsequence

    // held write that must leave the fields alone
    sequence pair_refused_s;
        pair_held_s ##0 (wsel == SEL_NONE || !st.w_lane0);
    endsequence

    // fields move only when a mapped, strobed write lands
    cfg_quiet_a: assert property (@(posedge clk) disable iff (!resetn)
        !(st.aw_held && st.w_held) |=> $stable(st.cfg))
        else $error("fields changed without a write");
    refused_keep_a: assert property (@(posedge clk) disable iff (!resetn)
        pair_refused_s |=> $stable(st.cfg) && s_axi_bvalid)
        else $error("refused write touched fields");
    wdata_drop_a: assert property (@(posedge clk) disable iff (!resetn)
        s_axi_wvalid && s_axi_wready |=> st.w_held && st.w_data == $past(s_axi_wdata[6:0]))
        else $error("write data capture wrong");
    unmapped_read_a: assert property (@(posedge clk) disable iff (!resetn)
        s_axi_arvalid && s_axi_arready && rsel == SEL_NONE |=>
        s_axi_rvalid && s_axi_rdata == 32'h0)
        else $error("unmapped read not zero");
endmodule

// File: verilog/slot_cfg_if.sv
// Purpose: carries one channel's stored fields to its slot decoder and back
// Assumes: single clock domain
// Notes: decoded fields are registered inside the decoder
`timescale 1ns/1ns
interface slot_cfg_if;
    logic [6:0] cfg;
    logic line_sel;
    logic [5:0] frame_slot;
    logic right_phase;
    logic [4:0] phase_slot;
    modport bank (output cfg, input line_sel, frame_slot, right_phase, phase_slot);
    modport dec (input cfg, output line_sel, frame_slot, right_phase, phase_slot);
endinterface

// File: verilog/slot_cfg_pkg.sv
// Purpose: constants for the channel 3..5 slot configuration bank
// Assumes: AXI4-Lite bus with 32-bit data, one register per aligned word
// Notes: printed offsets are word indices; byte address is four times the index
package slot_cfg_pkg;
    localparam int NUM_CHAN = 3;
    localparam int CFG_W = 7;
    // printed register indices
    localparam logic [5:0] CH3_INDEX = 6'h0d;
    localparam logic [5:0] CH4_INDEX = 6'h0e;
    localparam logic [5:0] CH5_INDEX = 6'h0f;
    // field positions
    localparam int LINE_SEL_BIT = 6;
    localparam int SLOT_MSB = 5;
    localparam int PHASE_BIT = 5;
    localparam int SLOT_W = 6;
    localparam int PHASE_SLOT_W = 5;
    // reset values, channel 3 in the low entry
    localparam logic [6:0] CH3_RESET = 7'h02;
    localparam logic [6:0] CH4_RESET = 7'h03;
    localparam logic [6:0] CH5_RESET = 7'h04;
    localparam logic [2:0][6:0] CFG_RESET = {CH5_RESET, CH4_RESET, CH3_RESET};
    // bus answers, and the select value for no register
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] SEL_NONE = 2'h3;
endpackage

// File: verilog/slot_decoder.sv
// Purpose: decodes one channel's line select and slot code into placement
// Assumes: cfg is stable register output of the bank
// Notes: outputs lag the stored fields by one clock
`timescale 1ns/1ns
module slot_decoder
    import slot_cfg_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // configuration and decoded placement
    slot_cfg_if.dec sc
);
    typedef struct packed {
        logic line_sel;
        logic [5:0] frame_slot;
        logic right_phase;
        logic [4:0] phase_slot;
    } dec_state_t;

    dec_state_t st;
    dec_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.line_sel = sc.cfg[LINE_SEL_BIT];
        next_st.frame_slot = sc.cfg[SLOT_MSB:0];
        // upper half of the code space is the right phase, n minus 32
        next_st.right_phase = sc.cfg[PHASE_BIT];
        next_st.phase_slot = sc.cfg[PHASE_SLOT_W-1:0];
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sc.line_sel = st.line_sel;
    assign sc.frame_slot = st.frame_slot;
    assign sc.right_phase = st.right_phase;
    assign sc.phase_slot = st.phase_slot;

    left_phase_a: assert property (@(posedge clk) disable iff (!resetn)
        $past(resetn) && $past(sc.cfg[5:0]) < 6'h20 |->
        !sc.right_phase && sc.phase_slot == $past(sc.cfg[4:0]))
        else $error("left phase slot wrong");
    right_phase_a: assert property (@(posedge clk) disable iff (!resetn)
        $past(resetn) && $past(sc.cfg[5:0]) >= 6'h20 |->
        sc.right_phase && {1'b0, sc.phase_slot} == $past(sc.cfg[5:0]) - 6'h20)
        else $error("right phase slot wrong");
endmodule
